// ==== pkg/i2c_ms_defines.vh ====
`ifndef I2C_MS_DEFINES_VH
`define I2C_MS_DEFINES_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_CTRL  4'h0
`define OFS_MCTRL 4'h1
`define OFS_MCMD  4'h2
`define OFS_MSTAT 4'h3
`define OFS_MADDR 4'h4
`define OFS_MDATA 4'h5
`define OFS_SCTRL 4'h6
`define OFS_SADDR 4'h7
`define OFS_SSTAT 4'h8
`define OFS_SDATA 4'h9
// ----------------------------------------
// field positions
// ----------------------------------------
`define CT_EXT    0
`define MC_EN     0
`define MC_TO_LO  1
`define MC_TO_HI  2
`define MC_ACKACT 3
`define SC_EN     0
`define SC_PROM   1
`define SC_NACK   2
`define ST_RDIF   7
`define ST_WAIF   6
`define ST_ARB    3
`define ST_BERR   2
// ----------------------------------------
// encodings and reset values
// ----------------------------------------
`define BS_UNKNOWN  2'b00
`define BS_IDLE     2'b01
`define BS_OWNER    2'b10
`define BS_BUSY     2'b11
`define CMD_RSTART  2'b01
`define CMD_BYTEREC 2'b10
`define CMD_STOP    2'b11
`define RST_BYTE    8'h00
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_MHZ   20
`define TO_50_US  50
`define TO_100_US 100
`define TO_200_US 200
`endif

// ==== core/i2c_master_slave.v ====
`include "i2c_ms_defines.vh"
`default_nettype none
module i2c_master_slave #(
  parameter HALF = 5
)(
  // clock and reset
  input  wire       i_clk,
  input  wire       i_rst,
  // register port
  input  wire [3:0] i_addr,
  input  wire [7:0] i_wdata,
  input  wire       i_wr,
  input  wire       i_rd,
  output reg  [7:0] o_rdata,
  // port pins 0..3
  input  wire [3:0] i_pin,
  output wire [3:0] o_pin,
  output wire [3:0] o_pin_oe_n
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  localparam [2:0] M_IDLE = 3'd0, M_WAIT = 3'd1, M_GEN = 3'd2;
  localparam [2:0] M_BIT = 3'd3, M_HOLD = 3'd4, M_STOP = 3'd5;
  localparam [2:0] A_ADDR = 3'd0, A_TXD = 3'd1, A_RXD = 3'd2;
  localparam [2:0] A_STOP = 3'd3, A_RST = 3'd4;
  localparam [2:0] S_IDLE = 3'd0, S_ADDR = 3'd1, S_AACK = 3'd2, S_RX = 3'd3;
  localparam [2:0] S_RACK = 3'd4, S_TXW = 3'd5, S_TX = 3'd6, S_TACK = 3'd7;
  localparam integer HM1 = HALF - 1;
  localparam integer T50 = `TO_50_US * `CLK_MHZ;
  localparam integer T100 = `TO_100_US * `CLK_MHZ;
  localparam integer T200 = `TO_200_US * `CLK_MHZ;
  localparam [7:0] HLIM = HM1[7:0];
  localparam [11:0] TO1 = T50[11:0];
  localparam [11:0] TO2 = T100[11:0];
  localparam [11:0] TO3 = T200[11:0];

  reg  [1:0]  sy1_reg, sy2_reg, prev_reg, line_reg, dly_reg;
  reg         ext_reg, m_en_reg, ackact_reg, s_en_reg, prom_reg, nack_reg;
  reg  [1:0]  to_reg, bs_reg;
  reg  [11:0] idle_cnt_reg;
  reg  [6:0]  s_adr_reg;
  reg  [2:0]  ms_reg, aft_reg, ss_reg;
  reg  [1:0]  ph_reg;
  reg  [7:0]  cnt_reg, m_adr_reg, m_rxd_reg, rx_reg;
  reg  [8:0]  tx_reg, chk_reg;
  reg  [3:0]  nb_reg, sb_reg;
  reg         m_sda_reg, m_scl_reg, m_lost_reg;
  reg         rif_reg, wif_reg, received_acknowledge_flag_reg, arb_reg, berr_reg;
  reg  [7:0]  s_sh_reg, s_tx_reg, s_data_reg;
  reg         dif_reg, apif_reg, s_received_acknowledge_flag_reg, coll_reg, s_berr_reg;
  reg         dir_reg, ap_reg, s_sda_reg;
  reg  [7:0]  rd_mux;
  reg         s_want;
  reg  [11:0] to_lim;

  wire sda = line_reg[0];
  wire scl = line_reg[1];
  wire start_det = scl & dly_reg[1] & dly_reg[0] & ~sda;
  wire stop_det = scl & dly_reg[1] & ~dly_reg[0] & sda;
  wire scl_rise = scl & ~dly_reg[1];
  wire hdone = (cnt_reg == HLIM);
  wire own = (ms_reg == M_GEN) | (ms_reg == M_BIT);
  wire tout = (to_reg != 2'b00) & (idle_cnt_reg >= to_lim);
  wire wr_ctrl = i_wr & (i_addr == `OFS_CTRL);
  wire wr_mctrl = i_wr & (i_addr == `OFS_MCTRL);
  wire wr_mcmd = i_wr & (i_addr == `OFS_MCMD);
  wire wr_mstat = i_wr & (i_addr == `OFS_MSTAT);
  wire wr_madr = i_wr & (i_addr == `OFS_MADDR);
  wire wr_mdat = i_wr & (i_addr == `OFS_MDATA);
  wire wr_sctrl = i_wr & (i_addr == `OFS_SCTRL);
  wire wr_sadr = i_wr & (i_addr == `OFS_SADDR);
  wire wr_sstat = i_wr & (i_addr == `OFS_SSTAT);
  wire wr_sdat = i_wr & (i_addr == `OFS_SDATA);
  wire [7:0] s_byte = {s_sh_reg[6:0], sda};
  wire s_match = prom_reg | (s_byte[7:1] == s_adr_reg) | (s_byte[7:1] == 7'h00);
  // a held slave stops stretching once it has collided
  wire s_scl = s_en_reg & ~coll_reg & (apif_reg | dif_reg) & ~scl;
  wire sda_pull = m_sda_reg | s_sda_reg;
  wire scl_pull = m_scl_reg | s_scl;

  // ----------------------------------------
  // pins, synchroniser and glitch filter
  // ----------------------------------------
  assign o_pin = {ext_reg & ~scl_pull, ext_reg & ~sda_pull, 2'b00};
  assign o_pin_oe_n = ext_reg ? 4'b0011 : {2'b11, ~scl_pull, ~sda_pull};

  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      sy1_reg <= 2'b11;
      sy2_reg <= 2'b11;
      prev_reg <= 2'b11;
      line_reg <= 2'b11;
      dly_reg <= 2'b11;
    end
    else
    begin
      sy1_reg <= i_pin[1:0];
      sy2_reg <= sy1_reg;
      prev_reg <= sy2_reg;
      dly_reg <= line_reg;
      // filter takes a level only after two equal samples; bypassed when external
      if (ext_reg)
        line_reg <= sy2_reg;
      else
        line_reg <= (~(sy2_reg ^ prev_reg) & sy2_reg) | ((sy2_reg ^ prev_reg) & line_reg);
    end
  end

  // ----------------------------------------
  // control registers and timeout
  // ----------------------------------------
  always @*
  begin
    case (to_reg)
      2'b01:   to_lim = TO1;
      2'b10:   to_lim = TO2;
      default: to_lim = TO3;
    endcase
  end

  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      ext_reg <= 1'b0;
      m_en_reg <= 1'b0;
      to_reg <= 2'b00;
      ackact_reg <= 1'b0;
      s_en_reg <= 1'b0;
      prom_reg <= 1'b0;
      nack_reg <= 1'b0;
      s_adr_reg <= 7'h00;
      idle_cnt_reg <= 12'h000;
    end
    else
    begin
      if (wr_ctrl)
        ext_reg <= i_wdata[`CT_EXT];
      if (wr_mctrl)
      begin
        m_en_reg <= i_wdata[`MC_EN];
        to_reg <= i_wdata[`MC_TO_HI:`MC_TO_LO];
        ackact_reg <= i_wdata[`MC_ACKACT];
      end
      if (wr_sctrl)
      begin
        s_en_reg <= i_wdata[`SC_EN];
        prom_reg <= i_wdata[`SC_PROM];
        nack_reg <= i_wdata[`SC_NACK];
      end
      if (wr_sadr)
        s_adr_reg <= i_wdata[7:1];
      if ((line_reg != dly_reg) | (to_reg == 2'b00))
        idle_cnt_reg <= 12'h000;
      else if (~tout)
        idle_cnt_reg <= idle_cnt_reg + 12'h001;
    end
  end

  // ----------------------------------------
  // bus state tracker
  // ----------------------------------------
  always @(posedge i_clk)
  begin
    if (i_rst | ~m_en_reg)
      bs_reg <= `BS_UNKNOWN;
    else if (wr_mstat & (i_wdata[1:0] == `BS_IDLE))
      bs_reg <= `BS_IDLE;
    else
    begin
      case (bs_reg)
        `BS_UNKNOWN: if (stop_det | tout) bs_reg <= `BS_IDLE;
        `BS_IDLE:    if (start_det) bs_reg <= own ? `BS_OWNER : `BS_BUSY;
        `BS_OWNER:
        begin
          if (m_lost_reg)
            bs_reg <= `BS_BUSY;
          else if (stop_det)
            bs_reg <= `BS_IDLE;
        end
        default:     if (stop_det | tout) bs_reg <= `BS_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // master engine
  // ----------------------------------------
  task ld;
    input [8:0] t;
    input [8:0] c;
    input [3:0] n;
    input [2:0] a;
    begin
      ms_reg <= M_BIT;
      ph_reg <= 2'd0;
      cnt_reg <= 8'h00;
      m_scl_reg <= 1'b1;
      tx_reg <= t;
      chk_reg <= c;
      nb_reg <= n;
      aft_reg <= a;
    end
  endtask

  task lose;
    input be;
    begin
      arb_reg <= 1'b1;
      wif_reg <= 1'b1;
      if (be)
        berr_reg <= 1'b1;
      m_sda_reg <= 1'b0;
      m_scl_reg <= 1'b0;
      ms_reg <= M_IDLE;
      m_lost_reg <= 1'b1;
    end
  endtask

  always @(posedge i_clk)
  begin
    m_lost_reg <= 1'b0;
    if (i_rst | ~m_en_reg)
    begin
      ms_reg <= M_IDLE;
      aft_reg <= A_ADDR;
      ph_reg <= 2'd0;
      cnt_reg <= 8'h00;
      nb_reg <= 4'd0;
      tx_reg <= 9'h1ff;
      chk_reg <= 9'h000;
      rx_reg <= `RST_BYTE;
      m_adr_reg <= `RST_BYTE;
      m_rxd_reg <= `RST_BYTE;
      m_sda_reg <= 1'b0;
      m_scl_reg <= 1'b0;
      rif_reg <= 1'b0;
      wif_reg <= 1'b0;
      received_acknowledge_flag_reg <= 1'b0;
      arb_reg <= 1'b0;
      berr_reg <= 1'b0;
    end
    else
    begin
      // clears first so that a flag set in the same cycle wins
      if (wr_mcmd | wr_madr | wr_mdat)
      begin
        rif_reg <= 1'b0;
        wif_reg <= 1'b0;
      end
      if (wr_mstat)
      begin
        if (i_wdata[`ST_RDIF]) rif_reg <= 1'b0;
        if (i_wdata[`ST_WAIF]) wif_reg <= 1'b0;
        if (i_wdata[`ST_ARB]) arb_reg <= 1'b0;
        if (i_wdata[`ST_BERR]) berr_reg <= 1'b0;
      end
      case (ms_reg)
        M_IDLE:
        begin
          m_sda_reg <= 1'b0;
          m_scl_reg <= 1'b0;
          if (wr_madr)
          begin
            m_adr_reg <= i_wdata;
            ms_reg <= M_WAIT;
          end
        end
        M_WAIT:
        begin
          if (bs_reg == `BS_IDLE)
          begin
            ms_reg <= M_GEN;
            ph_reg <= 2'd1;
            cnt_reg <= 8'h00;
          end
        end
        M_GEN:
        begin
          cnt_reg <= cnt_reg + 8'h01;
          if (ph_reg == 2'd0)
          begin
            m_sda_reg <= 1'b0;
            if (hdone)
            begin
              ph_reg <= 2'd1;
              cnt_reg <= 8'h00;
              m_scl_reg <= 1'b0;
            end
          end
          else if (ph_reg == 2'd1)
          begin
            if (bs_reg == `BS_BUSY)
              ms_reg <= M_WAIT;
            else if (~scl)
              cnt_reg <= 8'h00;
            else if (hdone & ~sda)
              lose(1'b0);
            else if (hdone)
            begin
              m_sda_reg <= 1'b1;
              ph_reg <= 2'd2;
              cnt_reg <= 8'h00;
            end
          end
          else if (hdone)
            ld({m_adr_reg, 1'b1}, 9'h1fe, 4'd9, A_ADDR);
        end
        M_BIT:
        begin
          cnt_reg <= cnt_reg + 8'h01;
          if (start_det | stop_det)
            lose(1'b1);
          else if (ph_reg == 2'd0)
          begin
            // data changes two cycles after the clock falls, never with it
            if (cnt_reg == 8'h01)
              m_sda_reg <= ~tx_reg[8];
            if (hdone)
            begin
              ph_reg <= 2'd1;
              cnt_reg <= 8'h00;
              m_scl_reg <= 1'b0;
            end
          end
          else if (~scl)
            cnt_reg <= 8'h00;
          else if (hdone)
          begin
            rx_reg <= {rx_reg[6:0], sda};
            ph_reg <= 2'd0;
            cnt_reg <= 8'h00;
            m_scl_reg <= 1'b1;
            if (chk_reg[8] & tx_reg[8] & ~sda)
              lose(1'b0);
            else if (nb_reg != 4'd1)
            begin
              tx_reg <= {tx_reg[7:0], 1'b1};
              chk_reg <= {chk_reg[7:0], 1'b0};
              nb_reg <= nb_reg - 4'd1;
            end
            else
            begin
              ms_reg <= M_HOLD;
              case (aft_reg)
                A_ADDR:
                begin
                  received_acknowledge_flag_reg <= sda;
                  if (sda | ~m_adr_reg[0])
                    wif_reg <= 1'b1;
                  else
                    ld(9'h1ff, 9'h000, 4'd8, A_RXD);
                end
                A_TXD:
                begin
                  wif_reg <= 1'b1;
                  received_acknowledge_flag_reg <= sda;
                end
                A_RXD:
                begin
                  rif_reg <= 1'b1;
                  received_acknowledge_flag_reg <= 1'b0;
                  m_rxd_reg <= {rx_reg[6:0], sda};
                end
                A_STOP: ms_reg <= M_STOP;
                default: ms_reg <= M_GEN;
              endcase
            end
          end
        end
        M_HOLD:
        begin
          if (~rif_reg & ~wif_reg)
            m_scl_reg <= 1'b0;
          cnt_reg <= 8'h00;
          ph_reg <= 2'd0;
          if (wr_mdat & ~m_adr_reg[0])
            ld({i_wdata, 1'b1}, 9'h1fe, 4'd9, A_TXD);
          else if (wr_madr)
          begin
            m_adr_reg <= i_wdata;
            m_scl_reg <= 1'b1;
            ms_reg <= M_GEN;
          end
          else if (wr_mcmd)
          begin
            m_scl_reg <= 1'b1;
            case (i_wdata[1:0])
              `CMD_RSTART:
                if (m_adr_reg[0]) ld({ackact_reg, 8'hff}, 9'h100, 4'd1, A_RST);
                else ms_reg <= M_GEN;
              `CMD_BYTEREC:
                if (m_adr_reg[0]) ld({ackact_reg, 8'hff}, 9'h100, 4'd9, A_RXD);
              `CMD_STOP:
                if (m_adr_reg[0]) ld({ackact_reg, 8'hff}, 9'h100, 4'd1, A_STOP);
                else ms_reg <= M_STOP;
              default: m_scl_reg <= m_scl_reg;
            endcase
          end
        end
        default:
        begin
          cnt_reg <= cnt_reg + 8'h01;
          if (ph_reg == 2'd0)
          begin
            if (cnt_reg == 8'h01)
              m_sda_reg <= 1'b1;
            if (hdone)
            begin
              ph_reg <= 2'd1;
              cnt_reg <= 8'h00;
              m_scl_reg <= 1'b0;
            end
          end
          else if (ph_reg == 2'd1)
          begin
            if (~scl)
              cnt_reg <= 8'h00;
            else if (hdone)
            begin
              ph_reg <= 2'd2;
              cnt_reg <= 8'h00;
            end
          end
          else if (hdone)
          begin
            m_sda_reg <= 1'b0;
            ms_reg <= M_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // slave engine
  // ----------------------------------------
  always @*
  begin
    case (ss_reg)
      S_AACK:  s_want = ~nack_reg;
      S_RACK:  s_want = ~nack_reg;
      S_TX:    s_want = ~s_tx_reg[7];
      default: s_want = 1'b0;
    endcase
  end

  always @(posedge i_clk)
  begin
    if (i_rst | ~s_en_reg)
    begin
      ss_reg <= S_IDLE;
      sb_reg <= 4'd0;
      s_sh_reg <= `RST_BYTE;
      s_tx_reg <= `RST_BYTE;
      s_data_reg <= `RST_BYTE;
      dif_reg <= 1'b0;
      apif_reg <= 1'b0;
      s_received_acknowledge_flag_reg <= 1'b0;
      coll_reg <= 1'b0;
      s_berr_reg <= 1'b0;
      dir_reg <= 1'b0;
      ap_reg <= 1'b0;
      s_sda_reg <= 1'b0;
    end
    else
    begin
      if (wr_sstat)
      begin
        if (i_wdata[`ST_RDIF]) dif_reg <= 1'b0;
        if (i_wdata[`ST_WAIF]) apif_reg <= 1'b0;
        if (i_wdata[`ST_ARB]) coll_reg <= 1'b0;
        if (i_wdata[`ST_BERR]) s_berr_reg <= 1'b0;
      end
      if (wr_sdat)
        dif_reg <= 1'b0;
      if (wr_sdat & (ss_reg == S_TXW))
      begin
        s_tx_reg <= i_wdata;
        sb_reg <= 4'd0;
        ss_reg <= S_TX;
      end
      // drive changes only while the clock is low and no longer stretched, except that a collision releases it at once
      if (coll_reg)
        s_sda_reg <= 1'b0;
      else if (~scl & ~apif_reg & ~dif_reg)
        s_sda_reg <= s_want;
      if (start_det)
      begin
        ss_reg <= S_ADDR;
        sb_reg <= 4'd0;
      end
      else if (stop_det)
      begin
        ss_reg <= S_IDLE;
        if ((ss_reg == S_ADDR) & (sb_reg == 4'd0))
          s_berr_reg <= 1'b1;
        else
        begin
          apif_reg <= 1'b1;
          ap_reg <= 1'b0;
        end
      end
      else if (scl_rise)
      begin
        s_sh_reg <= s_byte;
        sb_reg <= sb_reg + 4'd1;
        case (ss_reg)
          S_ADDR:
            if (sb_reg == 4'd7)
            begin
              ss_reg <= s_match ? S_AACK : S_IDLE;
              if (s_match)
              begin
                s_data_reg <= s_byte;
                dir_reg <= sda;
                apif_reg <= 1'b1;
                ap_reg <= 1'b1;
              end
            end
          S_AACK, S_RACK:
          begin
            sb_reg <= 4'd0;
            if (nack_reg & ~sda)
            begin
              coll_reg <= 1'b1;
              ss_reg <= S_IDLE;
            end
            else if (nack_reg)
              ss_reg <= S_IDLE;
            else if ((ss_reg == S_AACK) & dir_reg)
            begin
              dif_reg <= 1'b1;
              ss_reg <= S_TXW;
            end
            else
              ss_reg <= S_RX;
          end
          S_RX:
            if (sb_reg == 4'd7)
            begin
              s_data_reg <= s_byte;
              dif_reg <= 1'b1;
              ss_reg <= S_RACK;
            end
          S_TX:
          begin
            s_tx_reg <= {s_tx_reg[6:0], 1'b1};
            if (s_tx_reg[7] & ~sda)
            begin
              coll_reg <= 1'b1;
              ss_reg <= S_IDLE;
            end
            else if (sb_reg == 4'd7)
              ss_reg <= S_TACK;
          end
          S_TACK:
          begin
            s_received_acknowledge_flag_reg <= sda;
            dif_reg <= 1'b1;
            ss_reg <= sda ? S_IDLE : S_TXW;
          end
          default: sb_reg <= 4'd0;
        endcase
      end
    end
  end

  // ----------------------------------------
  // register read, data one cycle after strobe
  // ----------------------------------------
  always @*
  begin
    case (i_addr)
      `OFS_CTRL:  rd_mux = {7'h00, ext_reg};
      `OFS_MCTRL: rd_mux = {4'h0, ackact_reg, to_reg, m_en_reg};
      `OFS_MSTAT: rd_mux = {rif_reg, wif_reg, m_scl_reg, received_acknowledge_flag_reg,
                            arb_reg, berr_reg, bs_reg};
      `OFS_MADDR: rd_mux = m_adr_reg;
      `OFS_MDATA: rd_mux = m_rxd_reg;
      `OFS_SCTRL: rd_mux = {5'h00, nack_reg, prom_reg, s_en_reg};
      `OFS_SADDR: rd_mux = {s_adr_reg, 1'b0};
      `OFS_SSTAT: rd_mux = {dif_reg, apif_reg, s_scl, s_received_acknowledge_flag_reg,
                            coll_reg, s_berr_reg, dir_reg, ap_reg};
      `OFS_SDATA: rd_mux = s_data_reg;
      default:    rd_mux = 8'h00;
    endcase
  end

  always @(posedge i_clk)
  begin
    if (i_rst | ~i_rd)
      o_rdata <= 8'h00;
    else
      o_rdata <= rd_mux;
  end
endmodule // i2c_master_slave
`default_nettype wire

// ==== tb/i2c_ms_checker_assertions.sv ====
`include "i2c_ms_defines.vh"
`default_nettype none
module i2c_ms_checker (
  // register side
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  // pins
  input wire logic [3:0] i_pin,
  input wire logic [3:0] o_pin,
  input wire logic [3:0] o_pin_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  // ----
  // properties
  // ----
  a_force_idle: assert property (i_wr && i_addr == `OFS_MSTAT && i_wdata[1:0] == 2'b01
    ##2 i_rd && i_addr == `OFS_MSTAT |=> o_rdata[1:0] == `BS_IDLE) else $error("no idle");
  a_cmd_clears: assert property (i_wr && i_addr == `OFS_MCMD
    ##2 i_rd && i_addr == `OFS_MSTAT |=> o_rdata[7:6] == 2'b00) else $error("flags kept");
  a_hold_scl: assert property ($past(i_rd && i_addr == `OFS_MSTAT)
    && o_rdata[7:6] != 2'b00 && o_rdata[3:2] == 2'b00 |-> o_rdata[5] && !o_pin_oe_n[1])
    else $error("no hold");
  a_owner_code: assert property ($past(i_rd && i_addr == `OFS_MSTAT)
    && o_rdata[7:6] != 2'b00 && o_rdata[3:2] == 2'b00 |-> o_rdata[1:0] == `BS_OWNER)
    else $error("not owner");
  a_clear_release: assert property (i_wr && i_addr == `OFS_MSTAT && i_wdata[7:6] == 2'b11
    |-> ##[1:3] o_pin_oe_n[1]) else $error("scl kept");
  a_arb_release: assert property ($past(i_rd && i_addr == `OFS_MSTAT) && o_rdata[3]
    |-> o_rdata[6] && !o_rdata[5]) else $error("arb flags");
  a_ext_dirs: assert property (!o_pin_oe_n[2]
    |-> o_pin_oe_n == 4'h3 && o_pin[1:0] == 2'b00) else $error("ext dirs");
  a_normal_quiet: assert property (o_pin_oe_n[2]
    |-> o_pin == 4'h0 && o_pin_oe_n[3]) else $error("normal pins");
endmodule // i2c_ms_checker
bind i2c_master_slave i2c_ms_checker i_chk (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pin(i_pin),
  .o_pin(o_pin), .o_pin_oe_n(o_pin_oe_n));
`default_nettype wire

// ==== tb/i2c_target_model.sv ====
`default_nettype none
module i2c_target_model #(
  parameter logic [6:0] ADDR = 7'h50
) (
  // bus lines
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  // data
  input  wire logic [7:0] i_tx,
  output var  logic       o_pull,
  output var  logic [7:0] o_rx
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh;
  logic       on = 1'b0;
  logic       first;
  logic       hit = 1'b0;
  logic       rd;
  int         cnt;
  initial
    o_pull = 1'b0;
  // ----
  // start arms the counter, stop drops the line
  // ----
  always @(i_sda)
    if (i_scl === 1'b1)
    begin
      on = !i_sda;
      first = 1'b1;
      cnt = 0;
      o_pull = 1'b0;
    end
  always @(posedge i_scl)
  begin
    if (cnt < 8)
      sh = {sh[6:0], i_sda};
    else if (rd && i_sda)
      hit = 1'b0;
    cnt = cnt + 1;
  end
  // a nack from the master clears hit so sda is freed for its stop
  always @(negedge i_scl)
    if (on)
    begin
      if (cnt == 8 && first)
        hit = (sh[7:1] == ADDR);
      if (cnt == 8 && first)
        rd = sh[0];
      if (cnt == 8 && !rd)
        o_rx = sh;
      if (cnt == 9)
        first = 1'b0;
      if (cnt == 9)
        cnt = 0;
      o_pull = (cnt == 8) ? hit && (first || !rd) : hit && rd && !first && !i_tx[7 - cnt];
    end
endmodule // i2c_target_model
`default_nettype wire

// ==== tb/i2c_master_slave_tb.sv ====
`include "i2c_ms_defines.vh"
`default_nettype none
module i2c_master_slave_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       i_clk = 1'b0;
  logic       i_rst = 1'b1;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic       i_wr = 1'b0;
  logic       i_rd = 1'b0;
  logic       bl_sda = 1'b0;
  logic       bl_scl = 1'b0;
  logic [7:0] v;
  logic       ack;
  int         n_fail = 0;
  int         n_tests = 0;
  wire  [7:0] o_rdata;
  wire  [3:0] o_pin;
  wire  [3:0] o_pin_oe_n;
  wire        p_sda;
  wire  [7:0] rx;
  wire        sda = !(!o_pin_oe_n[0] || p_sda || bl_sda);
  wire        scl = !(!o_pin_oe_n[1] || bl_scl);
  i2c_master_slave #(.HALF(5)) i_i2c_master_slave (.i_clk(i_clk), .i_rst(i_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_pin({2'b11, scl, sda}), .o_pin(o_pin), .o_pin_oe_n(o_pin_oe_n));
  i2c_target_model i_i2c_target_model (.i_scl(scl), .i_sda(sda), .i_tx(8'h5c),
    .o_pull(p_sda), .o_rx(rx));
  always #25 i_clk = ~i_clk;
  // ----
  // bus tasks
  // ----
  task automatic stop_test;
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic rd(input logic [3:0] a);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
    @(posedge i_clk);
  endtask
  task automatic poll(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    for (int k = 0; k < 600; k++)
    begin
      rd(a);
      if ((v & m) === e)
        return;
    end
    chk("poll", e, v & m);
    stop_test();
  endtask
  task automatic hf;
    repeat (4) @(posedge i_clk);
  endtask
  task automatic bb(input logic [8:0] w, input int n);
    for (int i = n - 1; i >= 0; i--)
    begin
      bl_sda <= !w[i];
      hf();
      bl_scl <= 1'b0;
      hf();
      ack = !sda;
      bl_scl <= 1'b1;
    end
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_regs;
    wr(`OFS_CTRL, 8'h01);
    chk("ext", 8'h3c, {o_pin_oe_n, o_pin});
    wr(`OFS_CTRL, 8'h00);
    wr(`OFS_MCTRL, 8'h01);
    rd(`OFS_MSTAT);
    chk("unknown", 8'h00, v);
    wr(`OFS_MSTAT, 8'h01);
    rd(`OFS_MSTAT);
    chk("forced", 8'h01, v);
    wr(`OFS_MCTRL, 8'h00);
    wr(`OFS_MCTRL, 8'h03);
    repeat (900) @(posedge i_clk);
    rd(`OFS_MSTAT);
    chk("early", 8'h00, v);
    repeat (150) @(posedge i_clk);
    rd(`OFS_MSTAT);
    chk("timeout", 8'h01, v);
    $display("regs done");
  endtask
  task automatic t_master;
    wr(`OFS_MCTRL, 8'h01);
    wr(`OFS_MADDR, 8'ha0);
    poll(`OFS_MSTAT, 8'h40, 8'h40);
    chk("addr ack", 8'h62, v);
    wr(`OFS_MDATA, 8'haa);
    poll(`OFS_MSTAT, 8'h40, 8'h40);
    chk("data ack", 8'h62, v);
    chk("sent", 8'haa, rx);
    wr(`OFS_MCMD, 8'h03);
    poll(`OFS_MSTAT, 8'h03, 8'h01);
    wr(`OFS_MADDR, 8'hb0);
    poll(`OFS_MSTAT, 8'h40, 8'h40);
    chk("nack", 8'h72, v);
    wr(`OFS_MSTAT, 8'hc0);
    wr(`OFS_MCMD, 8'h03);
    poll(`OFS_MSTAT, 8'h03, 8'h01);
    wr(`OFS_MCTRL, 8'h09);
    wr(`OFS_MADDR, 8'ha1);
    poll(`OFS_MSTAT, 8'h80, 8'h80);
    chk("read", 8'ha2, v);
    rd(`OFS_MDATA);
    chk("rdata", 8'h5c, v);
    wr(`OFS_MCMD, 8'h03);
    poll(`OFS_MSTAT, 8'h03, 8'h01);
    $display("master done");
  endtask
  task automatic t_arb;
    wr(`OFS_MADDR, 8'ha0);
    for (int k = 0; k < 200 && scl; k++)
      @(posedge i_clk);
    bl_sda <= 1'b1;
    poll(`OFS_MSTAT, 8'h08, 8'h08);
    rd(`OFS_MSTAT);
    chk("arb", 8'h4b, v & 8'hef);
    bl_sda <= 1'b0;
    poll(`OFS_MSTAT, 8'h03, 8'h01);
    $display("arb done");
  endtask
  task automatic t_slave;
    wr(`OFS_SADDR, 8'h60);
    wr(`OFS_SCTRL, 8'h01);
    bl_sda <= 1'b1;
    hf();
    bl_scl <= 1'b1;
    hf();
    rd(`OFS_MSTAT);
    chk("busy", 8'h03, v & 8'h03);
    bb(9'h060, 8);
    poll(`OFS_SSTAT, 8'h40, 8'h40);
    chk("sstat", 8'h41, v & 8'h43);
    rd(`OFS_SDATA);
    chk("saddr", 8'h60, v);
    wr(`OFS_SSTAT, 8'h40);
    bb(9'h001, 1);
    chk("sack", 8'h01, {7'h00, ack});
    bl_sda <= 1'b1;
    hf();
    bl_scl <= 1'b0;
    for (int k = 0; k < 99 && !scl; k++)
      @(posedge i_clk);
    hf();
    bl_sda <= 1'b0;
    poll(`OFS_SSTAT, 8'h41, 8'h40);
    poll(`OFS_MSTAT, 8'h03, 8'h01);
    wr(`OFS_SSTAT, 8'h40);
    bl_sda <= 1'b1;
    hf();
    bl_sda <= 1'b0;
    poll(`OFS_SSTAT, 8'h04, 8'h04);
    $display("slave done");
  endtask
  initial
  begin
    repeat (60000) @(posedge i_clk);
    chk("watchdog", 8'h00, 8'h01);
    stop_test();
  end
  initial
  begin
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    t_regs();
    t_master();
    t_arb();
    t_slave();
    stop_test();
  end
endmodule // i2c_master_slave_tb
`default_nettype wire
